/* src/cla_arbiter.sv */
// Control-location arbiter with link watchdog and USB-stick logging control.
// Assumes asynchronous pins pass through two flops here; host messages arrive as AXI writes.
module cla_arbiter
   import cla_pkg::*;
#(
   parameter int TICK_CYC = CLA_TICK_CYC
)
(
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   // Pins and front panel
   input wire logic I_ANALOG_REMOTE,
   input wire logic I_PANEL_OUT_TOGGLE,
   input wire logic I_ALARM_OFF,
   input wire logic I_RESISTANCE_MODE,
   input wire logic I_STICK_OK,
   // AXI4-Lite write
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // AXI4-Lite read
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // Status outputs
   output logic [1:0] O_LOCATION,
   output logic O_DC_OUTPUT,
   output logic O_LOG_ACTIVE,
   output logic O_LOG_ERROR,
   output logic O_WDT_EXPIRED
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [4:0] sync1_r, sync2_r;
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end
      else
      begin
         sync1_r <= {I_STICK_OK, I_RESISTANCE_MODE, I_ALARM_OFF, I_PANEL_OUT_TOGGLE,
                     I_ANALOG_REMOTE};
         sync2_r <= sync1_r;
      end
   end
   logic ana_req, panel_tgl, alarm_off, res_mode, stick_ok, panel_tgl_d_r;
   assign {stick_ok, res_mode, alarm_off, panel_tgl, ana_req} = sync2_r;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   assign wr_go = aw_got_r && w_got_r && !O_BVALID;
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         O_AWREADY <= 1'b0;
         O_WREADY <= 1'b0;
         O_BVALID <= 1'b0;
         O_BRESP <= 2'b00;
      end
      else
      begin
         O_AWREADY <= !aw_got_r && !O_AWREADY && !O_BVALID;
         O_WREADY <= !w_got_r && !O_WREADY && !O_BVALID;
         if (I_AWVALID && O_AWREADY)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= I_AWADDR;
            O_AWREADY <= 1'b0;
         end
         if (I_WVALID && O_WREADY)
         begin
            w_got_r <= 1'b1;
            wdata_r <= I_WDATA;
            wstrb_r <= I_WSTRB;
            O_WREADY <= 1'b0;
         end
         if (wr_go)
         begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP <= (awaddr_r > CLA_OFF_SETVAL) ? 2'b10 : 2'b00;
         end
         else if (O_BVALID && I_BREADY)
            O_BVALID <= 1'b0;
      end
   end
   logic wr_ctrl, wr_host, wr_wdt, wr_log, wr_setval;
   assign wr_ctrl = wr_go && awaddr_r == CLA_OFF_CTRL && wstrb_r[0];
   assign wr_host = wr_go && awaddr_r == CLA_OFF_HOSTCMD && wstrb_r[0];
   assign wr_wdt = wr_go && awaddr_r == CLA_OFF_WDT && wstrb_r[1:0] == 2'h3;
   assign wr_log = wr_go && awaddr_r == CLA_OFF_LOGCMD && wstrb_r[1:0] == 2'h3;
   assign wr_setval = wr_go && awaddr_r == CLA_OFF_SETVAL;

   // ------------------------------------------------------------
   // Control settings
   // ------------------------------------------------------------
   logic [3:0] ctrl_r;
   logic [31:0] setval_r;
   logic [CLA_FILE_MAX:1] used_r;
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
         ctrl_r <= CLA_CTRL_RST[3:0];
      else if (wr_ctrl)
         ctrl_r <= wdata_r[3:0];
      else if (wr_host && wdata_r[CLA_HCMD_IFACE])
         ctrl_r[CLA_CTRL_WDT_EN] <= wdata_r[CLA_HCMD_MSG];
   end
   logic local_lock, keep_on, coupled, wdt_en;
   assign local_lock = ctrl_r[CLA_CTRL_LOCAL];
   assign keep_on = ctrl_r[CLA_CTRL_KEEP_ON];
   assign coupled = ctrl_r[CLA_CTRL_COUPLED];
   assign wdt_en = ctrl_r[CLA_CTRL_WDT_EN];

   // ------------------------------------------------------------
   // Control location and host errors
   // ------------------------------------------------------------
   cla_loc_t loc_r;
   logic host_err_r, expire;
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         loc_r <= CLA_LOC_MANUAL;
         host_err_r <= 1'b0;
      end
      else
      begin
         if (wr_host && wdata_r[CLA_HCMD_ENTER] && (local_lock || loc_r == CLA_LOC_ANALOG))
            host_err_r <= 1'b1;
         else if (wr_host && wdata_r[CLA_HCMD_ENTER])
            host_err_r <= 1'b0;
         unique case (loc_r)
            CLA_LOC_MANUAL:
               if (!local_lock && ana_req)
                  loc_r <= CLA_LOC_ANALOG;
               else if (!local_lock && wr_host && wdata_r[CLA_HCMD_ENTER])
                  loc_r <= CLA_LOC_DIGITAL;
            CLA_LOC_DIGITAL:
               if (local_lock || expire || (wr_host && wdata_r[CLA_HCMD_LEAVE]))
                  loc_r <= CLA_LOC_MANUAL;
            CLA_LOC_ANALOG:
               if (local_lock || !ana_req)
                  loc_r <= CLA_LOC_MANUAL;
            default:
               loc_r <= CLA_LOC_MANUAL;
         endcase
      end
   end

   // ------------------------------------------------------------
   // DC output and set values
   // ------------------------------------------------------------
   logic host_ctl;
   assign host_ctl = loc_r == CLA_LOC_DIGITAL;
   always_ff @(posedge I_CLOCK)
   begin
      panel_tgl_d_r <= I_RESET ? 1'b0 : panel_tgl;
      if (I_RESET)
         O_DC_OUTPUT <= 1'b0;
      else if (alarm_off)
         O_DC_OUTPUT <= 1'b0;
      else if (expire && !keep_on)
         O_DC_OUTPUT <= 1'b0;
      else if (host_ctl && wr_host && wdata_r[CLA_HCMD_OUT_ON])
         O_DC_OUTPUT <= 1'b1;
      else if (host_ctl && wr_host && wdata_r[CLA_HCMD_OUT_OFF])
         O_DC_OUTPUT <= 1'b0;
      else if (loc_r == CLA_LOC_MANUAL && panel_tgl && !panel_tgl_d_r)
         O_DC_OUTPUT <= !O_DC_OUTPUT;
   end
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
         setval_r <= 32'h0000_0000;
      else if (wr_setval && (loc_r != CLA_LOC_ANALOG))
         setval_r <= wdata_r;
   end

   // ------------------------------------------------------------
   // Link watchdog
   // ------------------------------------------------------------
   // The Ethernet connection timeout lives elsewhere and is not touched here.
   logic [$clog2(TICK_CYC)-1:0] div_r;
   logic tick;
   logic [15:0] wdt_cnt_r, wdt_pend_r, wdt_load_r;
   logic wdt_run;
   assign wdt_run = host_ctl && wdt_en;
   assign tick = div_r == ($clog2(TICK_CYC))'(TICK_CYC - 1);
   assign expire = wdt_run && tick && wdt_cnt_r == 16'h0001;
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET || tick)
         div_r <= '0;
      else
         div_r <= div_r + 1'b1;
   end
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
         wdt_pend_r <= CLA_WDT_RST;
      else if (wr_wdt && wdata_r[15:0] != 16'h0000)
         wdt_pend_r <= wdata_r[15:0];
   end
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         wdt_cnt_r <= CLA_WDT_RST;
         wdt_load_r <= CLA_WDT_RST;
         O_WDT_EXPIRED <= 1'b0;
      end
      else
      begin
         O_WDT_EXPIRED <= expire;
         if (!wdt_run)
            wdt_cnt_r <= wdt_load_r;
         else if (tick && wdt_cnt_r == 16'h0001)
         begin
            wdt_cnt_r <= wdt_pend_r;
            wdt_load_r <= wdt_pend_r;
         end
         else if (wr_host)
            wdt_cnt_r <= wdt_load_r;
         else if (tick)
            wdt_cnt_r <= wdt_cnt_r - 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Logging control
   // ------------------------------------------------------------
   logic out_d_r, out_on, out_off, log_start, log_stop;
   logic [10:0] file_r;
   logic [32:0] bytes_r;
   logic [31:0] ms_r;
   logic [10:0] next_file;
   logic has_free;
   always_comb
   begin
      next_file = CLA_FILE_FIRST;
      has_free = 1'b0;
      for (int i = int'(CLA_FILE_MAX); i >= 1; i--)
         if (!used_r[i])
         begin
            next_file = 11'(i);
            has_free = 1'b1;
         end
   end
   assign out_on = O_DC_OUTPUT && !out_d_r;
   assign out_off = !O_DC_OUTPUT && out_d_r;
   assign log_start = !O_LOG_ACTIVE && (coupled ? out_on
                      : (wr_log && wdata_r[CLA_LCMD_START]));
   assign log_stop = coupled ? out_off : (wr_log && wdata_r[CLA_LCMD_STOP]);
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         out_d_r <= 1'b0;
         O_LOG_ACTIVE <= 1'b0;
         O_LOG_ERROR <= 1'b0;
         file_r <= 11'h000;
         bytes_r <= 33'h0_0000_0000;
         ms_r <= 32'h0000_0000;
         used_r <= '0;
      end
      else
      begin
         out_d_r <= O_DC_OUTPUT;
         if (tick && O_LOG_ACTIVE)
            ms_r <= ms_r + 32'h0000_0001;
         if (wr_log && wdata_r[CLA_LCMD_USED] && wdata_r[26:16] != 11'h000
             && wdata_r[26:16] <= CLA_FILE_MAX)
            used_r[wdata_r[26:16]] <= 1'b1;
         if (log_start && (!has_free || !stick_ok))
            O_LOG_ERROR <= 1'b1;
         else if (log_start)
         begin
            O_LOG_ACTIVE <= 1'b1;
            O_LOG_ERROR <= 1'b0;
            file_r <= next_file;
            used_r[next_file] <= 1'b1;
            bytes_r <= 33'h0_0000_0000;
            ms_r <= 32'h0000_0000;
         end
         else if (log_stop)
            O_LOG_ACTIVE <= 1'b0;
         else if (O_LOG_ACTIVE && (!stick_ok || (wr_log && wdata_r[CLA_LCMD_FAIL])))
         begin
            O_LOG_ACTIVE <= 1'b0;
            O_LOG_ERROR <= 1'b1;
         end
         else if (O_LOG_ACTIVE && tick)
         begin
            if (bytes_r + 33'(CLA_REC_BYTES) > CLA_FILE_BYTES_MAX)
            begin
               O_LOG_ACTIVE <= 1'b0;
               O_LOG_ERROR <= 1'b1;
            end
            else
               bytes_r <= bytes_r + 33'(CLA_REC_BYTES);
         end
      end
   end

   // ------------------------------------------------------------
   // Read path: always answers, whatever the location
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (I_ARADDR)
         CLA_OFF_CTRL: rd_mux = {28'h0, ctrl_r};
         CLA_OFF_WDT: rd_mux = {wdt_cnt_r, wdt_pend_r};
         CLA_OFF_STATUS: rd_mux = {23'h0, res_mode, host_err_r, O_WDT_EXPIRED, O_LOG_ERROR,
                                   O_LOG_ACTIVE, O_DC_OUTPUT, local_lock, loc_r};
         CLA_OFF_LOGFILE: rd_mux = {21'h0, file_r};
         CLA_OFF_LOGTIME: rd_mux = ms_r;
         CLA_OFF_SETVAL: rd_mux = setval_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         O_ARREADY <= 1'b0;
         O_RVALID <= 1'b0;
         O_RDATA <= 32'h0000_0000;
         O_RRESP <= 2'b00;
      end
      else
      begin
         O_ARREADY <= !O_ARREADY && !O_RVALID && I_ARVALID;
         if (I_ARVALID && O_ARREADY)
         begin
            O_RVALID <= 1'b1;
            O_RDATA <= rd_mux;
            O_RRESP <= (I_ARADDR > CLA_OFF_SETVAL || I_ARADDR == CLA_OFF_HOSTCMD
                        || I_ARADDR == CLA_OFF_LOGCMD) ? 2'b10 : 2'b00;
         end
         else if (O_RVALID && I_RREADY)
            O_RVALID <= 1'b0;
      end
   end
   always_ff @(posedge I_CLOCK)
      O_LOCATION <= I_RESET ? 2'b00 : loc_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_analog_refuse: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      loc_r == CLA_LOC_ANALOG && !local_lock && ana_req |=> loc_r == CLA_LOC_ANALOG)
      else $error("Analog control lost while pin requests it.");
   a_digital_hold: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      loc_r == CLA_LOC_DIGITAL && !local_lock && !expire && !wr_host
      |=> loc_r == CLA_LOC_DIGITAL)
      else $error("Digital control changed without cause.");
   a_lock_manual: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      local_lock |=> loc_r == CLA_LOC_MANUAL)
      else $error("Remote control held under local lock.");
   a_wdt_idle: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      !wdt_run |=> wdt_cnt_r == $past(wdt_load_r) && !O_WDT_EXPIRED)
      else $error("Watchdog ran outside digital control.");
   a_wdt_leave: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      expire |=> loc_r == CLA_LOC_MANUAL && O_WDT_EXPIRED && ($past(keep_on) || !O_DC_OUTPUT))
      else $error("Expiry did not leave remote control.");
   a_wdt_restart: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      wdt_run && wr_host && !(tick && wdt_cnt_r == 16'h0001)
      |=> wdt_cnt_r == $past(wdt_load_r))
      else $error("Message did not restart the watchdog.");
   a_log_start: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      coupled && out_on && !O_LOG_ACTIVE && has_free && stick_ok |=> O_LOG_ACTIVE)
      else $error("Output on did not start logging.");
   a_log_stop: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
      coupled && out_off && O_LOG_ACTIVE |=> !O_LOG_ACTIVE)
      else $error("Output off did not stop logging.");

endmodule : cla_arbiter

/* src/cla_pkg.sv */
// Package for the control-location arbiter: register map, fields, reset values, timing.
// Assumes a 25 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package cla_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CLA_OFF_CTRL = 8'h00;
   localparam logic [7:0] CLA_OFF_HOSTCMD = 8'h04;
   localparam logic [7:0] CLA_OFF_WDT = 8'h08;
   localparam logic [7:0] CLA_OFF_LOGCMD = 8'h0C;
   localparam logic [7:0] CLA_OFF_STATUS = 8'h10;
   localparam logic [7:0] CLA_OFF_LOGFILE = 8'h14;
   localparam logic [7:0] CLA_OFF_LOGTIME = 8'h18;
   localparam logic [7:0] CLA_OFF_SETVAL = 8'h1C;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CLA_CTRL_LOCAL = 0;
   localparam int CLA_CTRL_KEEP_ON = 1;
   localparam int CLA_CTRL_COUPLED = 2;
   localparam int CLA_CTRL_WDT_EN = 3;
   localparam int CLA_HCMD_ENTER = 0;
   localparam int CLA_HCMD_LEAVE = 1;
   localparam int CLA_HCMD_MSG = 2;
   localparam int CLA_HCMD_IFACE = 3;
   localparam int CLA_HCMD_OUT_ON = 4;
   localparam int CLA_HCMD_OUT_OFF = 5;
   localparam int CLA_HCMD_SETVAL = 6;
   localparam int CLA_LCMD_START = 0;
   localparam int CLA_LCMD_STOP = 1;
   localparam int CLA_LCMD_FAIL = 2;
   localparam int CLA_LCMD_USED = 3;

   // ------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------
   localparam logic [31:0] CLA_CTRL_RST = 32'h0000_0008;
   localparam logic [15:0] CLA_WDT_RST = 16'h03E8;
   localparam logic [10:0] CLA_FILE_MAX = 11'h400;
   localparam logic [10:0] CLA_FILE_FIRST = 11'h001;
   localparam logic [32:0] CLA_FILE_BYTES_MAX = 33'h1_0000_0000;
   localparam logic [15:0] CLA_REC_BYTES = 16'h0040;

   // ------------------------------------------------------------
   // Timing: watchdog tick of 1 ms
   // ------------------------------------------------------------
   localparam int CLA_CLK_HZ = 25000000;
   localparam int CLA_TICK_US = 1000;
   localparam int CLA_TICK_CYC = CLA_CLK_HZ / 1000000 * CLA_TICK_US;

   typedef enum logic [1:0]
   {
      CLA_LOC_MANUAL = 2'b00,
      CLA_LOC_DIGITAL = 2'b01,
      CLA_LOC_ANALOG = 2'b10
   } cla_loc_t;

endpackage : cla_pkg

/* verif/cla_host_model.sv */
// Host model: an AXI4-Lite master in place of the PC or PLC on the far side.
// Assumes the slave outputs are registered, so values seen at an edge are the sampled ones.
module cla_host_model
   import cla_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Write channels
   output logic [7:0] o_awaddr,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready,
   // Read channels
   output logic [7:0] o_araddr,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
      {o_araddr, o_arvalid, o_rready} = '0;
   end

   // Every write to CLA_OFF_HOSTCMD is one host message; the bench decides how often messages go out.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (o_awvalid && i_awready)
            o_awvalid <= 1'b0;
         if (o_wvalid && i_wready)
            o_wvalid <= 1'b0;
      end
      while (i_bvalid !== 1'b1);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (o_arvalid && i_arready)
            o_arvalid <= 1'b0;
      end
      while (i_rvalid !== 1'b1);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask : rd
endmodule : cla_host_model

/* verif/tb_control_location_arbiter.sv */
// Bench for the control-location arbiter: scenario tasks judged against expected values.
// Assumes the host model for all register traffic and a 10-cycle watchdog tick.
module tb_control_location_arbiter
   import cla_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // A short tick keeps the 1000-tick default timeout within a short run.
   localparam int TCK = 10;
   logic clk = 1'b0, rst = 1'b1, analog = 1'b0, tog = 1'b0, alarm = 1'b0, rmode = 1'b0;
   logic stick = 1'b1, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, o_dc, o_act, o_err, o_exp;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, o_loc;
   int n_mismatch = 0, cmp_count = 0, cyc_n = 0;

   always #20 clk = ~clk;

   cla_host_model h (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
      .i_awready(awready), .o_wdata(wdata), .o_wvalid(wvalid), .i_wready(wready),
      .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
      .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
      .i_rvalid(rvalid), .o_rready(rready));

   cla_arbiter #(.TICK_CYC(TCK)) dut (.I_CLOCK(clk), .I_RESET(rst), .I_ANALOG_REMOTE(analog),
      .I_PANEL_OUT_TOGGLE(tog), .I_ALARM_OFF(alarm), .I_RESISTANCE_MODE(rmode),
      .I_STICK_OK(stick), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
      .O_RVALID(rvalid), .I_RREADY(rready), .O_LOCATION(o_loc), .O_DC_OUTPUT(o_dc),
      .O_LOG_ACTIVE(o_act), .O_LOG_ERROR(o_err), .O_WDT_EXPIRED(o_exp));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      h.wr(a, d, r);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                         input logic [1:0] er = 2'b00);
      logic [31:0] d;
      logic [1:0] r;
      h.rd(a, d, r);
      chk(d & m, e);
      chk({30'h0, r}, {30'h0, er});
   endtask : reg_rd

   task automatic loc_is(input logic [1:0] e);
      cyc(6);
      chk({30'h0, o_loc}, {30'h0, e});
   endtask : loc_is

   // Expected {output on, logging, log error}.
   task automatic st_is(input logic [2:0] e);
      cyc(6);
      chk({29'h0, o_dc, o_act, o_err}, {29'h0, e});
   endtask : st_is

   task automatic press;
      tog <= 1'b1;
      cyc(5);
      tog <= 1'b0;
   endtask : press

   task automatic t_reset;
      rmode <= 1'b1;
      loc_is(2'b00);
      reg_rd(CLA_OFF_CTRL, CLA_CTRL_RST, 32'hFFFFFFFF);
      reg_rd(CLA_OFF_WDT, 32'h3E8, 32'hFFFF);
      reg_rd(8'h20, 32'h0, 32'h0, 2'b10);
      reg_rd(CLA_OFF_STATUS, 32'h100, 32'h100);
      rmode <= 1'b0;
      $display("test reset done");
   endtask : t_reset

   task automatic t_analog;
      analog <= 1'b1;
      loc_is(2'b10);
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      loc_is(2'b10);
      reg_rd(CLA_OFF_STATUS, 32'h82, 32'h83);
      reg_wr(CLA_OFF_CTRL, 32'h9);
      loc_is(2'b00);
      reg_wr(CLA_OFF_CTRL, 32'h8);
      loc_is(2'b10);
      analog <= 1'b0;
      loc_is(2'b00);
      $display("test analog done");
   endtask : t_analog

   task automatic t_digital;
      reg_wr(CLA_OFF_SETVAL, 32'h1234);
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      loc_is(2'b01);
      reg_rd(CLA_OFF_SETVAL, 32'h1234, 32'hFFFFFFFF);
      analog <= 1'b1;
      loc_is(2'b01);
      reg_rd(CLA_OFF_STATUS, 32'h1, 32'h3);
      analog <= 1'b0;
      reg_wr(CLA_OFF_CTRL, 32'h9);
      loc_is(2'b00);
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      loc_is(2'b00);
      reg_wr(CLA_OFF_CTRL, 32'h8);
      loc_is(2'b00);
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      loc_is(2'b01);
      reg_wr(CLA_OFF_HOSTCMD, 32'h2);
      loc_is(2'b00);
      $display("test digital done");
   endtask : t_digital

   task automatic t_log;
      logic [31:0] d;
      logic [1:0] r;
      reg_wr(CLA_OFF_CTRL, 32'hC);
      press();
      st_is(3'b110);
      reg_rd(CLA_OFF_LOGFILE, 32'h1, 32'h7FF);
      press();
      st_is(3'b000);
      reg_wr(CLA_OFF_LOGCMD, 32'h0003_0008);
      press();
      reg_rd(CLA_OFF_LOGFILE, 32'h2, 32'h7FF);
      alarm <= 1'b1;
      st_is(3'b000);
      alarm <= 1'b0;
      press();
      reg_rd(CLA_OFF_LOGFILE, 32'h4, 32'h7FF);
      press();
      reg_wr(CLA_OFF_CTRL, 32'h8);
      press();
      st_is(3'b100);
      reg_wr(CLA_OFF_LOGCMD, 32'h1);
      st_is(3'b110);
      // About 110 cycles after the start, so 10 or 11 ticks have been counted.
      cyc(100);
      h.rd(CLA_OFF_LOGTIME, d, r);
      chk({31'h0, d >= 32'hA && d <= 32'hD}, 32'h1);
      alarm <= 1'b1;
      st_is(3'b010);
      alarm <= 1'b0;
      reg_wr(CLA_OFF_LOGCMD, 32'h2);
      st_is(3'b000);
      reg_wr(CLA_OFF_LOGCMD, 32'h1);
      reg_wr(CLA_OFF_LOGCMD, 32'h4);
      st_is(3'b001);
      $display("test logging done");
   endtask : t_log

   task automatic wait_exp(input int lim, output int n);
      n = 0;
      while (o_exp !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_exp

   task automatic t_wdt;
      int n;
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      reg_wr(CLA_OFF_HOSTCMD, 32'h10);
      st_is(3'b101);
      reg_wr(CLA_OFF_WDT, 32'h5);
      cyc(6000);
      reg_wr(CLA_OFF_HOSTCMD, 32'h4);
      cyc(6000);
      loc_is(2'b01);
      wait_exp(6000, n);
      chk({31'h0, n < 6000}, 32'h1);
      st_is(3'b001);
      loc_is(2'b00);
      reg_wr(CLA_OFF_CTRL, 32'hA);
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      reg_wr(CLA_OFF_HOSTCMD, 32'h10);
      wait_exp(200, n);
      chk({31'h0, n >= 30 && n < 80}, 32'h1);
      st_is(3'b101);
      loc_is(2'b00);
      reg_wr(CLA_OFF_HOSTCMD, 32'h1);
      reg_wr(CLA_OFF_HOSTCMD, 32'h8);
      cyc(300);
      loc_is(2'b01);
      reg_wr(CLA_OFF_HOSTCMD, 32'hC);
      wait_exp(200, n);
      chk({31'h0, n >= 30 && n < 80}, 32'h1);
      loc_is(2'b00);
      $display("test watchdog done");
   endtask : t_wdt

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   always @(posedge clk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 60000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial
   begin
      cyc(3);
      rst <= 1'b0;
      cyc(1);
      t_reset();
      t_analog();
      t_digital();
      t_log();
      t_wdt();
      report_and_stop();
   end
endmodule : tb_control_location_arbiter
